// *** hdl/lpw_unit.sv ***
// Notes on behaviour
// - setting the stop bit enters stop once the writing instruction retires.
// - stop halts cpu and precision oscillator; other oscillators left as is.
// - only a reset ends stop; core restarts at vector zero.
// - enabled missing-clock detector resets and ends stop.
// - suspend bit six gates system clock and stops all internal oscillators.
// - during suspend all digital logic halts until an enabled wake event.
// - suspend wakes on capsense, rtc fail, rtc alarm, port match, comparator rise.
// - flags read zero for two clocks after leaving suspend.
// - short reset-pin glitch ends suspend; software waits 15 us to re-enter.
// - any reset-pin falling edge ends sleep; 15 us wait before re-entry.
// - sleep bit seven turns off core regulator, ram to supply pin.
// - digital output pins hold their levels through sleep.
// - digital input pins stay live in sleep for port match wake.
// - with wake output enabled, drive wake request low on sleep exit.
// - sleep keeps ram, registers, program counter and all volatile state.
// - sleep wakes only on rtc fail, rtc alarm, port match, comparator rise and a reset-pin falling edge.
// - mode bit five disables supply monitor; any reset then is full por.
// - reset pin is always a wake source; stay awake over 15 us.
// - flags keep updating after wake, enabled or not.
// - entry refused while any enabled flag is set.
// - clear bit clears every wake flag at once.
// - after suspend or sleep wake, execution continues at next instruction.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
module lpw_unit #(
   parameter int PIN_WAIT = lpw_pkg::PIN_WAIT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // events and pins
   input wire lpw_pkg::lpw_event_t event_i,
   input wire logic reset_pin_n_i,
   input wire logic clock_missing_i,
   input wire logic clock_monitor_en_i,
   input wire logic instr_done_i,
   // power controls
   output lpw_pkg::lpw_power_t power_o,
   output logic wake_request_o,
   output logic wake_request_oe_n_o,
   output logic internal_reset_o,
   output logic full_por_o,
   output logic supply_monitor_en_o,
   output logic resume_next_o,
   output logic [31:0] reset_vector_o,
   output logic [2:0] state_o
);

   // -------------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------------
   logic [4:0] ev_m_r, ev_s_r, ev_d_r;
   logic pin_m_r, pin_s_r, pin_d_r;
   logic ev_pulse_cmp;
   logic pin_fall;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_m_r <= 5'h00;
         ev_s_r <= 5'h00;
         ev_d_r <= 5'h00;
         pin_m_r <= 1'b1;
         pin_s_r <= 1'b1;
         pin_d_r <= 1'b1;
      end else begin
         ev_m_r <= event_i;
         ev_s_r <= ev_m_r;
         ev_d_r <= ev_s_r;
         pin_m_r <= reset_pin_n_i;
         pin_s_r <= pin_m_r;
         pin_d_r <= pin_s_r;
      end
   end

   // comparator wakes only on a rising edge, reset pin on a falling edge; other sources are levels
   assign ev_pulse_cmp = ev_s_r[0] & ~ev_d_r[0];
   assign pin_fall = pin_d_r & ~pin_s_r;

   // -------------------------------------------------------------------
   // state and registers
   // -------------------------------------------------------------------
   lpw_pkg::lpw_state_t state_r;
   logic [3:0] cfg_en_r;    // rtc fail, rtc alarm, port match, comparator
   logic cs_en_r;
   logic [3:0] cfg_fl_r;
   logic cs_fl_r;
   logic rst_fl_r;
   logic [7:0] mode_r;
   logic stop_r;
   logic [1:0] hold_r;
   logic [2:0] osc_r;
   logic was_suspend_r;
   logic was_sleep_r;
   logic mon_off_seen_r;

   logic wr, rd, wr_cfg, wr_flag, wr_mode, wr_ctrl;
   logic [4:0] ev_now;
   logic enter_sleep, enter_suspend, blocked;
   logic [4:0] en_now, fl_now;
   logic wake_suspend, wake_sleep;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   assign wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
   assign rd = cyc_i & stb_i & ~we_i & ~ack_o;
   assign wr_cfg = wr & hit(adr_i, lpw_pkg::OFS_CONFIG);
   assign wr_flag = wr & hit(adr_i, lpw_pkg::OFS_FLAG);
   assign wr_mode = wr & hit(adr_i, lpw_pkg::OFS_MODE);
   assign wr_ctrl = wr & hit(adr_i, lpw_pkg::OFS_CTRL);

   assign ev_now = {ev_s_r[4:1], ev_pulse_cmp};

   // config enables used at entry are those in this very write; capsense enable is the stored one
   assign en_now = {cs_en_r, wr_cfg ? dat_i[3:0] : cfg_en_r};
   assign fl_now = {cs_fl_r, cfg_fl_r};
   assign blocked = |(en_now & fl_now) | rst_fl_r;
   assign enter_sleep = wr_cfg & dat_i[lpw_pkg::CFG_SLEEP] & ~blocked;
   assign enter_suspend = wr_cfg & dat_i[lpw_pkg::CFG_SUSPEND] & ~dat_i[lpw_pkg::CFG_SLEEP] & ~blocked;

   assign wake_suspend = |(ev_now & {cs_en_r, cfg_en_r}) | pin_fall;
   // sleep sources exclude capsense; reset pin always
   assign wake_sleep = |(ev_now[3:0] & cfg_en_r) | pin_fall;

   // -------------------------------------------------------------------
   // mode sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= lpw_pkg::LPW_RUN;
         osc_r <= 3'h0;
         was_suspend_r <= 1'b0;
         was_sleep_r <= 1'b0;
      end else begin
         case (state_r)
            lpw_pkg::LPW_RUN: begin
               // resume indication stands until the next mode entry
               if ((stop_r & instr_done_i) | enter_sleep | enter_suspend) begin
                  was_suspend_r <= 1'b0;
                  was_sleep_r <= 1'b0;
               end
               if (stop_r & instr_done_i) begin
                  state_r <= lpw_pkg::LPW_STOP;
               end else if (enter_sleep) begin
                  state_r <= lpw_pkg::LPW_SLEEP;
               end else if (enter_suspend) begin
                  state_r <= lpw_pkg::LPW_SUSPEND;
               end
            end
            lpw_pkg::LPW_STOP: state_r <= lpw_pkg::LPW_STOP;
            lpw_pkg::LPW_SUSPEND: begin
               if (wake_suspend) begin
                  state_r <= lpw_pkg::LPW_WAKE;
                  osc_r <= 3'h0;
                  was_suspend_r <= 1'b1;
               end
            end
            lpw_pkg::LPW_SLEEP: begin
               if (wake_sleep) begin
                  state_r <= lpw_pkg::LPW_RUN;
                  was_sleep_r <= 1'b1;
               end
            end
            lpw_pkg::LPW_WAKE: begin
               if (osc_r == 3'(lpw_pkg::OSC_START_CYC - 1)) begin
                  state_r <= lpw_pkg::LPW_RUN;
               end else begin
                  osc_r <= osc_r + 3'h1;
               end
            end
            default: state_r <= lpw_pkg::LPW_RUN;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // registers written by software
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_en_r <= lpw_pkg::SRC_MASK_RESET;
         cs_en_r <= 1'b0;
         mode_r <= lpw_pkg::MODE_RESET;
         stop_r <= 1'b0;
      end else begin
         if (wr_cfg) begin
            cfg_en_r <= dat_i[3:0];
         end
         if (wr_flag) begin
            cs_en_r <= dat_i[0];
         end
         if (wr_mode) begin
            mode_r <= dat_i[7:0] & lpw_pkg::MODE_USED;
         end
         if (wr_ctrl & dat_i[lpw_pkg::CTRL_STOP]) begin
            stop_r <= 1'b1;
         end else if (state_r == lpw_pkg::LPW_STOP) begin
            stop_r <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // wake flags
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_fl_r <= 4'h0;
         cs_fl_r <= 1'b0;
         rst_fl_r <= 1'b0;
      end else if (state_r != lpw_pkg::LPW_SUSPEND) begin
         // always updated; clear all, set wins
         cfg_fl_r <= (wr_cfg & dat_i[lpw_pkg::CFG_CLEAR] ? 4'h0 : cfg_fl_r) | ev_now[3:0];
         cs_fl_r <= (wr_cfg & dat_i[lpw_pkg::CFG_CLEAR] ? 1'b0 : cs_fl_r) | ev_now[4];
         rst_fl_r <= (wr_cfg & dat_i[lpw_pkg::CFG_CLEAR] ? 1'b0 : rst_fl_r) | pin_fall;
      end else begin
         cfg_fl_r <= cfg_fl_r | ev_now[3:0];
         cs_fl_r <= cs_fl_r | ev_now[4];
         rst_fl_r <= rst_fl_r | pin_fall;
      end
   end

   // flags masked two clocks after suspend
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_r <= 2'h0;
      end else if (state_r == lpw_pkg::LPW_WAKE && osc_r == 3'(lpw_pkg::OSC_START_CYC - 1)) begin
         hold_r <= 2'(lpw_pkg::FLAG_HOLD_CYC);
      end else if (hold_r != 2'h0) begin
         hold_r <= hold_r - 2'h1;
      end
   end

   // -------------------------------------------------------------------
   // supply monitor and resets
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mon_off_seen_r <= 1'b0;
      end else begin
         mon_off_seen_r <= mode_r[lpw_pkg::MODE_MON_OFF];
      end
   end

   logic reset_req;
   assign reset_req = clock_monitor_en_i & clock_missing_i;
   assign internal_reset_o = reset_req;
   // monitor disable makes resets full por
   assign supply_monitor_en_o = ~mode_r[lpw_pkg::MODE_MON_OFF];
   assign full_por_o = reset_req & mon_off_seen_r;
   assign reset_vector_o = lpw_pkg::RESET_VECTOR;
   assign resume_next_o = was_sleep_r | (was_suspend_r & (state_r == lpw_pkg::LPW_RUN));

   // -------------------------------------------------------------------
   // power controls
   // -------------------------------------------------------------------
   always_comb begin
      power_o = '0;
      case (state_r)
         lpw_pkg::LPW_RUN: power_o.precision_osc_en = 1'b1;
         lpw_pkg::LPW_STOP: power_o.cpu_halt = 1'b1;
         lpw_pkg::LPW_SUSPEND: begin
            power_o.cpu_halt = 1'b1;
            power_o.all_osc_off = 1'b1;
            power_o.sysclk_gate = 1'b1;
         end
         lpw_pkg::LPW_SLEEP: begin
            // regulator off, ram retained; pins held
            power_o.cpu_halt = 1'b1;
            power_o.all_osc_off = 1'b1;
            power_o.sysclk_gate = 1'b1;
            power_o.core_reg_off = 1'b1;
            power_o.ram_on_supply = 1'b1;
            power_o.pin_hold = 1'b1;
         end
         lpw_pkg::LPW_WAKE: begin
            power_o.cpu_halt = 1'b1;
            power_o.precision_osc_en = 1'b1;
         end
         default: power_o.cpu_halt = 1'b1;
      endcase
   end

   // wake request low on sleep exit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_request_o <= 1'b1;
      end else begin
         // high through sleep so peers see one falling edge, on exit only
         wake_request_o <= ~(state_r == lpw_pkg::LPW_SLEEP && wake_sleep);
      end
   end
   assign wake_request_oe_n_o = ~mode_r[lpw_pkg::MODE_WAKE_OUT];
   assign state_o = state_r;

   // -------------------------------------------------------------------
   // wishbone read and ack
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= lpw_pkg::RD_ZERO;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         if (rd) begin
            dat_o <= lpw_pkg::RD_ZERO;
            if (hold_r == 2'h0) begin
               if (hit(adr_i, lpw_pkg::OFS_CONFIG)) begin
                  dat_o[4:0] <= {rst_fl_r, cfg_fl_r};
               end else if (hit(adr_i, lpw_pkg::OFS_FLAG)) begin
                  dat_o[0] <= cs_fl_r;
               end
            end
            if (hit(adr_i, lpw_pkg::OFS_MODE)) begin
               dat_o[7:0] <= mode_r;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   a_stop_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == lpw_pkg::LPW_RUN && stop_r && instr_done_i) |=> state_r == lpw_pkg::LPW_STOP)
      else $error("stop not entered");
   a_stop_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == lpw_pkg::LPW_STOP |=> state_r == lpw_pkg::LPW_STOP)
      else $error("stop left without reset");
   a_suspend_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == lpw_pkg::LPW_SUSPEND |-> power_o.sysclk_gate && power_o.all_osc_off)
      else $error("suspend clock not gated");
   a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == lpw_pkg::LPW_WAKE && $past(state_r) == lpw_pkg::LPW_WAKE && hold_r == 2'h0
       && osc_r == 3'(lpw_pkg::OSC_START_CYC - 1)) |=> hold_r != 2'h0 ##1 hold_r != 2'h0)
      else $error("flags not masked two clocks");
   a_sleep_reg: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == lpw_pkg::LPW_SLEEP |-> power_o.core_reg_off && power_o.ram_on_supply)
      else $error("sleep power wrong");
   a_pin_wake: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == lpw_pkg::LPW_SLEEP && pin_fall) |=> state_r == lpw_pkg::LPW_RUN && !wake_request_o)
      else $error("reset pin did not wake sleep");
   a_entry_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == lpw_pkg::LPW_RUN && !(stop_r && instr_done_i) && blocked) |=> state_r == lpw_pkg::LPW_RUN)
      else $error("entered with flag set");
   a_cs_no_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == lpw_pkg::LPW_SLEEP && (ev_now[3:0] & cfg_en_r) == 4'h0 && !pin_fall)
      |=> state_r == lpw_pkg::LPW_SLEEP)
      else $error("sleep woke on excluded source");
   a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_cfg && dat_i[lpw_pkg::CFG_CLEAR] && state_r != lpw_pkg::LPW_SUSPEND && ev_now == 5'h00 && !pin_fall)
      |=> cfg_fl_r == 4'h0 && !cs_fl_r && !rst_fl_r)
      else $error("flags not cleared");

endmodule

// *** pkg/lpw_pkg.sv ***
package lpw_pkg;

   // -------------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // -------------------------------------------------------------------
   localparam logic [3:0] OFS_CONFIG = 4'h0;  // power_unit_config_reg
   localparam logic [3:0] OFS_FLAG = 4'h4;    // power_unit_flag_reg
   localparam logic [3:0] OFS_MODE = 4'h8;    // power_unit_mode_reg
   localparam logic [3:0] OFS_CTRL = 4'hC;    // power_control_reg

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int CFG_SLEEP = 7;
   localparam int CFG_SUSPEND = 6;
   localparam int CFG_CLEAR = 5;
   localparam int CFG_PIN_FLAG = 4;
   localparam int MODE_WAKE_OUT = 6;
   localparam int MODE_MON_OFF = 5;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_IDLE = 0;

   localparam logic [3:0] SRC_MASK_RESET = 4'h0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODE_USED = 8'hE0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int PIN_WAIT_US = 15;
   localparam int PIN_WAIT_CYC = PIN_WAIT_US * CLK_MHZ;
   localparam int FLAG_HOLD_CYC = 2;
   localparam int OSC_START_CYC = 4;
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;

   typedef enum logic [2:0] {
      LPW_RUN = 3'b000,
      LPW_STOP = 3'b001,
      LPW_SUSPEND = 3'b010,
      LPW_SLEEP = 3'b011,
      LPW_WAKE = 3'b100
   } lpw_state_t;

   // wake events: bit0 comparator, 1 port match, 2 rtc alarm, 3 rtc fail, 4 capsense
   typedef struct packed {
      logic cap_sense;
      logic rtc_fail;
      logic rtc_alarm;
      logic port_match;
      logic cmp0_rise;
   } lpw_event_t;

   typedef struct packed {
      logic cpu_halt;
      logic precision_osc_en;
      logic all_osc_off;
      logic sysclk_gate;
      logic core_reg_off;
      logic ram_on_supply;
      logic pin_hold;
   } lpw_power_t;

endpackage

// *** bench/lpw_wake_listener.sv ***
module lpw_wake_listener (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic oe_n_i,
   output logic [7:0] wakes_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic line;
   logic line_r;
   // undriven pin floats to its pull-up
   assign line = oe_n_i ? 1'b1 : req_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_r <= 1'b1;
         wakes_o <= 8'h00;
      end else begin
         line_r <= line;
         if (line_r && !line) begin
            wakes_o <= wakes_o + 8'h01;
         end
      end
   end
endmodule

// *** bench/lpw_unit_bench.sv ***
module lpw_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h1;
   logic [31:0] dwr = 32'h0000_0000;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic ack_o;
   lpw_pkg::lpw_event_t ev = '0;
   logic pin_n = 1'b1;
   logic missing = 1'b0;
   logic mon_en = 1'b0;
   logic done = 1'b0;
   lpw_pkg::lpw_power_t pwr;
   logic wake_req;
   logic wake_oe_n;
   logic int_rst;
   logic full_por;
   logic mon_on;
   logic resume;
   logic [31:0] vec;
   logic [2:0] state_o;
   logic [7:0] wakes;
   int failures = 0;
   int n_tests = 0;

   always #2 clk_i = ~clk_i;

   lpw_unit uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dwr), .dat_o(dat_o), .ack_o(ack_o), .event_i(ev), .reset_pin_n_i(pin_n),
      .clock_missing_i(missing), .clock_monitor_en_i(mon_en), .instr_done_i(done), .power_o(pwr),
      .wake_request_o(wake_req), .wake_request_oe_n_o(wake_oe_n), .internal_reset_o(int_rst),
      .full_por_o(full_por), .supply_monitor_en_o(mon_on), .resume_next_o(resume),
      .reset_vector_o(vec), .state_o(state_o));

   lpw_wake_listener peer (.clk_i(clk_i), .rst_i(rst_i), .req_i(wake_req), .oe_n_i(wake_oe_n),
      .wakes_o(wakes));

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // ----------------------------------------
   // classic wishbone single cycle
   // ----------------------------------------
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dwr <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50) begin
         failures++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   task automatic wst(input logic [2:0] s);
      int n;
      n = 0;
      while (state_o !== s && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk({29'h0, state_o}, {29'h0, s});
   endtask

   task automatic pulse(input logic [4:0] v);
      @(posedge clk_i);
      ev <= lpw_pkg::lpw_event_t'(v);
      tick(3);
      ev <= '0;
      tick(4);
   endtask

   initial begin
      tick(20000);
      failures++;
      end_sim();
   end

   initial begin
      tick(16);
      rst_i <= 1'b0;
      // ----------------------------------------
      // reset values and register map
      // ----------------------------------------
      rdchk(lpw_pkg::OFS_MODE, 32'h0000_0000);
      chk({31'h0, mon_on}, 32'h0000_0001);
      chk({31'h0, wake_oe_n}, 32'h0000_0001);
      chk(vec, lpw_pkg::RESET_VECTOR);
      wr(4'h6, 32'h0000_00FF);
      rdchk(lpw_pkg::OFS_MODE, 32'h0000_0000);
      rdchk(4'h2, lpw_pkg::RD_ZERO);
      $display("test reset done");
      pulse(5'h1F);
      rdchk(lpw_pkg::OFS_CONFIG, 32'h0000_000F);
      rdchk(lpw_pkg::OFS_FLAG, 32'h0000_0001);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0020);
      rdchk(lpw_pkg::OFS_CONFIG, 32'h0000_0000);
      rdchk(lpw_pkg::OFS_FLAG, 32'h0000_0000);
      $display("test flags done");
      // only an enabled flag blocks entry
      pulse(5'h02);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0042);
      tick(4);
      chk({29'h0, state_o}, {29'h0, lpw_pkg::LPW_RUN});
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0041);
      wst(lpw_pkg::LPW_SUSPEND);
      pulse(5'h01);
      wst(lpw_pkg::LPW_RUN);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0020);
      $display("test refusal done");
      for (int i = 0; i < 5; i++) begin
         if (i == 4) begin
            wr(lpw_pkg::OFS_FLAG, 32'h0000_0001);
         end
         wr(lpw_pkg::OFS_CONFIG, 32'h0000_0040 | (i < 4 ? 32'(1 << i) : 32'h0000_0000));
         wst(lpw_pkg::LPW_SUSPEND);
         chk({31'h0, pwr.sysclk_gate}, 32'h0000_0001);
         chk({31'h0, pwr.all_osc_off}, 32'h0000_0001);
         chk({31'h0, pwr.cpu_halt}, 32'h0000_0001);
         pulse(5'(1 << i));
         wst(lpw_pkg::LPW_RUN);
         chk({31'h0, resume}, 32'h0000_0001);
         chk({31'h0, pwr.sysclk_gate}, 32'h0000_0000);
         rdchk(i == 4 ? lpw_pkg::OFS_FLAG : lpw_pkg::OFS_CONFIG, 32'(1 << (i % 4)));
         wr(lpw_pkg::OFS_CONFIG, 32'h0000_0020);
      end
      // reset-pin glitch ends suspend with only capsense enabled
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0040);
      wst(lpw_pkg::LPW_SUSPEND);
      pin_n <= 1'b0;
      tick(2);
      pin_n <= 1'b1;
      wst(lpw_pkg::LPW_RUN);
      rdchk(lpw_pkg::OFS_CONFIG, 32'h0000_0010);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0020);
      tick(lpw_pkg::PIN_WAIT_CYC);
      $display("test suspend done");
      // ----------------------------------------
      // sleep with wake request output
      // ----------------------------------------
      wr(lpw_pkg::OFS_MODE, 32'h0000_0040);
      chk({31'h0, wake_oe_n}, 32'h0000_0000);
      wr(lpw_pkg::OFS_FLAG, 32'h0000_0001);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_008F);
      wst(lpw_pkg::LPW_SLEEP);
      chk({31'h0, pwr.core_reg_off}, 32'h0000_0001);
      chk({31'h0, pwr.ram_on_supply}, 32'h0000_0001);
      chk({31'h0, pwr.pin_hold}, 32'h0000_0001);
      pulse(5'h10);
      chk({29'h0, state_o}, {29'h0, lpw_pkg::LPW_SLEEP});
      chk({24'h0, wakes}, 32'h0000_0000);
      pin_n <= 1'b0;
      tick(4);
      pin_n <= 1'b1;
      wst(lpw_pkg::LPW_RUN);
      tick(3);
      chk({24'h0, wakes}, 32'h0000_0001);
      chk({31'h0, wake_req}, 32'h0000_0001);
      chk({31'h0, resume}, 32'h0000_0001);
      rdchk(lpw_pkg::OFS_CONFIG, 32'h0000_0010);
      rdchk(lpw_pkg::OFS_FLAG, 32'h0000_0001);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0020);
      tick(lpw_pkg::PIN_WAIT_CYC);
      wr(lpw_pkg::OFS_CONFIG, 32'h0000_0082);
      wst(lpw_pkg::LPW_SLEEP);
      pulse(5'h02);
      wst(lpw_pkg::LPW_RUN);
      tick(2);
      chk({24'h0, wakes}, 32'h0000_0002);
      $display("test sleep done");
      // ----------------------------------------
      // stop mode and supply monitor
      // ----------------------------------------
      wr(lpw_pkg::OFS_MODE, 32'h0000_0020);
      chk({31'h0, mon_on}, 32'h0000_0000);
      wr(lpw_pkg::OFS_CTRL, 32'h0000_0002);
      tick(2);
      chk({29'h0, state_o}, {29'h0, lpw_pkg::LPW_RUN});
      done <= 1'b1;
      tick(1);
      done <= 1'b0;
      wst(lpw_pkg::LPW_STOP);
      chk({31'h0, pwr.cpu_halt}, 32'h0000_0001);
      chk({31'h0, pwr.precision_osc_en}, 32'h0000_0000);
      pulse(5'h02);
      chk({29'h0, state_o}, {29'h0, lpw_pkg::LPW_STOP});
      mon_en <= 1'b1;
      missing <= 1'b1;
      tick(2);
      chk({31'h0, int_rst}, 32'h0000_0001);
      chk({31'h0, full_por}, 32'h0000_0001);
      rst_i <= 1'b1;
      tick(2);
      rst_i <= 1'b0;
      mon_en <= 1'b0;
      missing <= 1'b0;
      tick(2);
      chk({29'h0, state_o}, {29'h0, lpw_pkg::LPW_RUN});
      chk({31'h0, mon_on}, 32'h0000_0001);
      $display("test stop done");
      end_sim();
   end
endmodule
